// [design/port_e_pkg.sv]
// Constants for the four-bit general-purpose port with one input-only pin.
// Assumes a plain register port with one-cycle strobes and a single clock.
//
// Behaviour
// - Four-bit port, three pins individually directional.
// - Analog-selected shared pins read as zero.
// - Direction bit one floats the pin driver.
// - Direction bit zero drives the latch bit.
// - Direction bits act even in analog mode.
// - Upper direction bits hold slave port status/mode.
// - Latch register readable, returns latched values.
// - Reset-pin select zero makes pin four input.
// - Fourth pin has no direction or latch.
// - Smallest package: only fourth pin, when select zero.
// - Port bits 3:0 implemented, 7:4 read zero.
// - Smallest package: slave port interrupt bits read zero.
package port_e_pkg;
  // Register offsets on the register port.
  localparam logic [3:0] addr_pin_level_port = 4'h0;
  localparam logic [3:0] addr_output_latch   = 4'h1;
  localparam logic [3:0] addr_direction_ctrl = 4'h2;
  localparam logic [3:0] addr_analog_select  = 4'h3;
  localparam logic [3:0] addr_slave_irq      = 4'h4;
  // Field positions in the direction register.
  localparam int pos_slave_port_mode   = 4;
  localparam int pos_slave_in_overflow = 5;
  localparam int pos_slave_out_full    = 6;
  localparam int pos_slave_in_full     = 7;
  // Field positions in the slave interrupt register.
  localparam int pos_irq_flag     = 0;
  localparam int pos_irq_enable   = 1;
  localparam int pos_irq_priority = 2;
  // Values after reset.
  localparam logic [2:0] reset_latch     = 3'h0;
  localparam logic [2:0] reset_direction = 3'h7;
  localparam logic [3:0] reset_slave     = 4'h0;
  localparam logic [2:0] reset_analog    = 3'h7;
  localparam logic [2:0] reset_irq       = 3'h0;
  localparam logic [2:0] reset_pin_out   = 3'h0;
  localparam logic [2:0] reset_pin_oe_n  = 3'h7;
  localparam logic [7:0] reset_rdata     = 8'h00;
  localparam logic       reset_master_clear_in_n    = 1'b1;
  // Pins that carry a direction and latch bit.
  localparam int shared_pins = 3;
endpackage : port_e_pkg

// [design/port_e_io.sv]
// Four-bit general-purpose port: three two-way pins and one input-only pin.
// Holds the latch, direction, analog select and slave port bits of the port.
// Pins are synchronous to mclk; configuration bits are static straps.
// The register port never stalls; reads answer one cycle after the strobe.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module port_e_io #(
  parameter bit small_package = 1'b0  // Selects the smallest package variant.
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register port.
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Configuration strap: one makes the fourth pin the master clear.
  input  wire logic       reset_pin_select,
  // Shared pins.
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_out,
  output logic      [2:0] pin_oe_n,
  // Fourth pin and its master clear use.
  input  wire logic       input_only_pin,
  output logic            master_clear_n
);
  logic [2:0] latch;      // Output latch bits.
  logic [2:0] direction;  // One means input.
  logic [3:0] slave;      // Slave port status and mode bits.
  logic [2:0] analog;     // One selects the pin as analog input.
  logic [2:0] irq;        // Slave port interrupt flag, enable, priority.
  logic       port_exist; // Port visible at all.
  logic       pin3_digital;
  logic [7:0] next_rdata;
  logic [2:0] shared_read; // Analog-masked shared pin levels.

  // The fourth pin is a port input only when master clear is off.
  assign pin3_digital = ~reset_pin_select;
  // Smallest package keeps only the fourth pin, and only as an input.
  assign port_exist = ~small_package | pin3_digital;

  // Latch register; a write to the port address also lands here.
  // Both addresses write the same flops; a read of the port address returns pin levels, not the latch.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch <= port_e_pkg::reset_latch;
    end else if (wr && (addr == port_e_pkg::addr_output_latch ||
                        addr == port_e_pkg::addr_pin_level_port)) begin
      latch <= wdata[2:0];
    end
  end

  // Direction bits in the low field; inputs after reset keep pins safe.
  // Bit three of the register is unimplemented and is not stored.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      direction <= port_e_pkg::reset_direction;
      slave     <= port_e_pkg::reset_slave;
    end else if (wr && addr == port_e_pkg::addr_direction_ctrl) begin
      direction <= wdata[2:0];
      // Only the mode bit is software writable; the status bits belong to the slave port.
      slave[0]  <= wdata[port_e_pkg::pos_slave_port_mode];
    end
  end

  // Analog selection comes up on every shared pin.
  // Reading analog pins as zero keeps a floating level out of software.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog <= port_e_pkg::reset_analog;
    end else if (wr && addr == port_e_pkg::addr_analog_select) begin
      analog <= wdata[2:0];
    end
  end

  // Slave port interrupt bits; absent on the smallest package.
  // The slave port logic itself lives elsewhere; only the bits are kept here.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= port_e_pkg::reset_irq;
    end else if (wr && addr == port_e_pkg::addr_slave_irq && !small_package) begin
      irq <= wdata[2:0];
    end
  end

  // Pin drivers, one copy per shared pin from a single generate loop.
  // They follow direction even in analog mode: keeping analog pins set as
  // inputs is software's care, and the hardware does not second-guess it.
  generate
    for (genvar gi = 0; gi < port_e_pkg::shared_pins; gi++) begin : g_pin
      // Enable and drive value of one pin, both straight from flip-flops.
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          // Floating after reset, so nothing fights the board during setup.
          pin_out[gi]  <= port_e_pkg::reset_pin_out[gi];
          pin_oe_n[gi] <= port_e_pkg::reset_pin_oe_n[gi];
        end else begin
          // Small package has no shared pins, so they never drive.
          pin_oe_n[gi] <= direction[gi] | small_package;
          pin_out[gi]  <= latch[gi];
        end
      end
      // Level of this pin as the port register shows it; analog reads zero.
      assign shared_read[gi] = pin_in[gi] & ~analog[gi] & ~small_package;
    end
  endgenerate

  // Master clear output is active low and follows the pin when selected.
  // Registered like every other output; the reset logic sees it one edge late.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_clear_n <= port_e_pkg::reset_master_clear_in_n;
    end else begin
      master_clear_n <= pin3_digital | input_only_pin;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  // Pin levels are read even on output pins, so a shorted pin shows up.
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      port_e_pkg::addr_pin_level_port: begin
        if (port_exist) begin
          next_rdata[2:0] = shared_read;
          next_rdata[3] = input_only_pin & pin3_digital;
        end
      end
      port_e_pkg::addr_output_latch: begin
        next_rdata = {5'h00, latch};
      end
      port_e_pkg::addr_direction_ctrl: begin
        next_rdata = {slave[3], slave[2], slave[1], slave[0], 1'b0, direction};
      end
      port_e_pkg::addr_analog_select: begin
        next_rdata = {5'h00, analog};
      end
      port_e_pkg::addr_slave_irq: begin
        next_rdata = small_package ? 8'h00 : {5'h00, irq};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data stand for one cycle after the strobe only.
  // Returning zero otherwise keeps stale data off the shared read bus.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= port_e_pkg::reset_rdata;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // Assertions. Each guards one rule of the design's side; they sit here
  // because most of them watch several registers at once.

  // A write strobe to the latch or to the port address.
  sequence s_latch_write;
    wr && (addr == port_e_pkg::addr_output_latch ||
           addr == port_e_pkg::addr_pin_level_port);
  endsequence

  // The written latch bits reach the pin drive two edges later.
  sequence s_drive_follows;
    ##2 (pin_out == $past(wdata[2:0], 2));
  endsequence

  // A write strobe to the direction register.
  sequence s_dir_write;
    wr && (addr == port_e_pkg::addr_direction_ctrl);
  endsequence

  // The written direction bits reach the pin enables two edges later.
  sequence s_enable_follows;
    ##2 (pin_oe_n == $past(wdata[2:0], 2));
  endsequence

  // A read strobe on the port address.
  sequence s_port_read;
    rd && (addr == port_e_pkg::addr_pin_level_port);
  endsequence

  // An input pin never drives, whatever else is set.
  // A driving input would fight the board.
  a_float_input: assert property (@(posedge mclk) disable iff (rst)
    direction[0] |=> pin_oe_n[0]) else $error("pin zero driven while input");

  // An output pin drives its latch bit one edge later.
  // The drive value is the latch, never the pin level.
  a_drive_latch: assert property (@(posedge mclk) disable iff (rst)
    (!direction[1] && !small_package) |=> (!pin_oe_n[1] && pin_out[1] == $past(latch[1])))
    else $error("pin one not driving latch");

  // An analog pin reads zero on the port register.
  // This hides the floating digital level from software.
  a_analog_zero: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_pin_level_port && analog[2]) |=> !rdata[2])
    else $error("analog pin read nonzero");

  // Analog selection does not override the direction bit.
  // Software must keep analog pins as inputs itself.
  a_analog_drive: assert property (@(posedge mclk) disable iff (rst)
    (analog[0] && !direction[0] && !small_package) |=> !pin_oe_n[0])
    else $error("direction ignored in analog mode");

  // Latch reads return the latch, not the pins.
  // This keeps read-modify-write of the latch safe.
  a_latch_read: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_output_latch) |=> rdata == {5'h00, $past(latch)})
    else $error("latch read mismatch");

  // The upper half of the port register is unimplemented.
  // It must read zero on every package.
  a_upper_zero: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_pin_level_port) |=> rdata[7:4] == 4'h0)
    else $error("port upper bits nonzero");

  // With the strap set, a low pin requests master clear.
  // The request lags the pin by one edge.
  a_master_clear_in_pin: assert property (@(posedge mclk) disable iff (rst)
    (reset_pin_select && !input_only_pin) |=> !master_clear_n)
    else $error("master clear not asserted");

  // With the strap set, the fourth port bit reads zero.
  // The pin then belongs to the reset logic alone.
  a_pin3_read: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_pin_level_port && reset_pin_select) |=> !rdata[3])
    else $error("fourth pin read while master clear");

  // The smallest package has no slave port interrupt bits.
  // They read zero whatever software wrote.
  a_small_irq: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_slave_irq && small_package) |=> rdata == 8'h00)
    else $error("irq bits present on small package");

  // The smallest package never drives a shared pin.
  // Those pins do not exist there.
  a_small_port: assert property (@(posedge mclk) disable iff (rst)
    small_package |=> pin_oe_n == 3'h7) else $error("small package drives pins");

  // A direction write lands in the low field only.
  // The upper bits go to the slave port, not to the pins.
  a_dir_upper: assert property (@(posedge mclk) disable iff (rst)
    (wr && addr == port_e_pkg::addr_direction_ctrl) |=> direction == $past(wdata[2:0]))
    else $error("direction write lost");

  // Right after reset every shared pin is analog.
  // Digital use must be chosen by software.
  a_pow_analog: assert property (@(posedge mclk) $fell(rst) |-> analog == 3'h7)
    else $error("analog not selected after reset");

  // A latch write shows on the pin drive two edges later.
  // One edge for the latch and one for the drive flops.
  a_latch_to_pin: assert property (@(posedge mclk) disable iff (rst)
    s_latch_write |-> s_drive_follows)
    else $error("latch write not seen on pin drive");

  // A direction write shows on the enables two edges later.
  // Only where the shared pins exist.
  a_dir_to_enable: assert property (@(posedge mclk) disable iff (rst)
    s_dir_write ##0 !small_package |-> s_enable_follows)
    else $error("direction write not seen on enables");

  // A digital output pin reads back its own level.
  // The board model resolves the driven level onto the pin.
  a_shared_level: assert property (@(posedge mclk) disable iff (rst)
    s_port_read ##0 (!analog[1] && !small_package) |=> rdata[1] == $past(pin_in[1]))
    else $error("shared pin level not read");

  // Analog pin one reads zero as well.
  // Each pin is masked by its own select bit.
  a_analog_one: assert property (@(posedge mclk) disable iff (rst)
    s_port_read ##0 analog[1] |=> !rdata[1])
    else $error("analog pin one read nonzero");

  // Without the strap the fourth bit reads the pin.
  // This holds on the smallest package too.
  a_fourth_level: assert property (@(posedge mclk) disable iff (rst)
    s_port_read ##0 !reset_pin_select |=> rdata[3] == $past(input_only_pin))
    else $error("fourth pin level not read");

  // The smallest package with the strap set has no port.
  // The whole register then reads zero.
  a_small_absent: assert property (@(posedge mclk) disable iff (rst)
    s_port_read ##0 (small_package && reset_pin_select) |=> rdata == 8'h00)
    else $error("port present without port");

  // The smallest package shows no shared pin levels.
  // Only the fourth pin can read nonzero there.
  a_small_shared: assert property (@(posedge mclk) disable iff (rst)
    s_port_read ##0 small_package |=> rdata[2:0] == 3'h0)
    else $error("shared pins read on small package");

  // The slave port status bits and bit three read zero here.
  // Status comes from the slave port, which is not part of this block.
  a_status_zero: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_direction_ctrl) |=> rdata[7:5] == 3'h0 && !rdata[3])
    else $error("slave status bits nonzero");

  // The slave port mode bit takes its written value.
  // It is the only writable bit of the upper field.
  a_mode_write: assert property (@(posedge mclk) disable iff (rst)
    s_dir_write |=> slave[0] == $past(wdata[port_e_pkg::pos_slave_port_mode]))
    else $error("slave port mode write lost");

  // A write to the port address updates the latch.
  // Writes never reach the pins' input side.
  a_port_latch: assert property (@(posedge mclk) disable iff (rst)
    (wr && addr == port_e_pkg::addr_pin_level_port) |=> latch == $past(wdata[2:0]))
    else $error("port write missed the latch");

  // The latch register implements only its low bits.
  // The rest read zero.
  a_latch_upper: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == port_e_pkg::addr_output_latch) |=> rdata[7:3] == 5'h00)
    else $error("latch upper bits nonzero");

  // Without the strap, master clear never asserts.
  // The pin is then a plain input.
  a_master_clear_in_idle: assert property (@(posedge mclk) disable iff (rst)
    !reset_pin_select |=> master_clear_n)
    else $error("master clear asserted while port pin");

  // With the strap set, a high pin releases master clear.
  // The request is active low.
  a_master_clear_in_release: assert property (@(posedge mclk) disable iff (rst)
    (reset_pin_select && input_only_pin) |=> master_clear_n)
    else $error("master clear stuck low");

  // The smallest package ignores writes to the interrupt bits.
  // They keep their reset value.
  a_irq_fixed: assert property (@(posedge mclk) disable iff (rst)
    small_package |=> irq == port_e_pkg::reset_irq)
    else $error("irq bits written on small package");

  // Read data are zero outside the cycle after a read strobe.
  // Stale data never linger on the bus.
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data without a read");

  // An analog select write takes effect on the next edge.
  // Software may then read the pins digitally.
  a_analog_write: assert property (@(posedge mclk) disable iff (rst)
    (wr && addr == port_e_pkg::addr_analog_select) |=> analog == $past(wdata[2:0]))
    else $error("analog select write lost");
endmodule : port_e_io

// [sim/board_pins.sv]
// Board model for the three shared pins of the port.
// Assumes the bench sets the level that the board puts on each pin.
`timescale 1ns/1ps
module board_pins (
  // Design side of the pins.
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  // Level that the board drives on a pin that the port leaves floating.
  input  wire logic [2:0] board_lvl,
  // Resolved pin levels.
  output logic      [2:0] pin_in
);
  // A driving port wins over the weak board level; floating pins show the board.
  assign pin_in = (pin_out & ~pin_oe_n) | (board_lvl & pin_oe_n);
endmodule : board_pins

// [sim/four_bit_port_e_io_bench.sv]
// Bench for the four-bit port: register reads, pin drive and the clear strap.
// Assumes the board model resolves the shared pin levels.
`timescale 1ns/1ps
module four_bit_port_e_io_bench;
  logic       mclk = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0, sel = 0, iop = 1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, lat, dir;
  logic [2:0] pin_in, pin_out, pin_oe_n, lvl = 3'h0, b, shr;
  logic       master_clear_in_n;
  logic [2:0] s_oe_n; // Enables of the smallest-package copy.
  logic [7:0] exp_q[$]; // Read results awaited by the monitor.
  int         seed = 24, n_fail = 0, check_count = 0;
  port_e_io DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .reset_pin_select(sel), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .input_only_pin(iop),
    .master_clear_n(master_clear_in_n));
  port_e_io #(.small_package(1'b1)) small_dut (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(), .reset_pin_select(sel), .pin_in(lvl),
    .pin_out(), .pin_oe_n(s_oe_n), .input_only_pin(iop), .master_clear_n());
  board_pins board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_lvl(lvl),
    .pin_in(pin_in));
  initial forever #10 mclk = ~mclk;
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // One-cycle strobes; the strobe drops one edge later, so calls may follow.
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge mclk) begin
    if (rd_seen) check("rdata", rdata, exp_q.pop_front());
    rd_seen <= rd;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h08);
    rd_reg(4'h1, 8'h00);
    rd_reg(4'h2, 8'h07);
    rd_reg(4'h3, 8'h07);
    rd_reg(4'h4, 8'h00);
    rd_reg(4'h9, 8'h00);
    $display("test done: reset values");
    // Outputs while still analog: the drivers obey direction regardless.
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h1, 8'h07);
    repeat (2) @(posedge mclk);
    check("oe_analog", {5'h0, pin_oe_n}, 8'h00);
    rd_reg(4'h0, 8'h08);
    wr_reg(4'h3, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lat = $random(seed);
      dir = $random(seed);
      b = $random(seed);
      lvl <= b;
      iop <= b[0];
      shr = (b & dir[2:0]) | (lat[2:0] & ~dir[2:0]);
      wr_reg(4'h1, lat);
      wr_reg(4'h2, dir);
      repeat (2) @(posedge mclk);
      check("oe_n", {5'h0, pin_oe_n}, {5'h0, dir[2:0]});
      check("small_oe_n", {5'h0, s_oe_n}, 8'h07);
      check("drive", {5'h0, pin_out & ~dir[2:0]}, {5'h0, lat[2:0] & ~dir[2:0]});
      rd_reg(4'h1, {5'h0, lat[2:0]});
      rd_reg(4'h2, {3'h0, dir[4], 1'b0, dir[2:0]});
      rd_reg(4'h0, {4'h0, b[0], shr});
    end
    $display("test done: pin direction and latch");
    // Strap the fourth pin as master clear; its port bit then reads zero.
    sel <= 1'b1;
    iop <= 1'b0;
    repeat (3) @(posedge mclk);
    check("master_clear_in_low", {7'h0, master_clear_in_n}, 8'h00);
    rd_reg(4'h0, {5'h0, shr});
    iop <= 1'b1;
    repeat (3) @(posedge mclk);
    check("master_clear_in_high", {7'h0, master_clear_in_n}, 8'h01);
    repeat (2) @(posedge mclk);
    $display("test done: master clear strap");
    tally_and_finish();
  end
endmodule : four_bit_port_e_io_bench
